//--- src/add_logic_branch_exec.sv
`timescale 1ns/1ps
module add_logic_branch_exec
  import abe_pkg::*;
#(
  parameter logic [31:0] RESET_ADDRESS = 32'h0000_0000
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);

  initial begin
    if (RESET_ADDRESS[1:0] != 2'b00) begin
      $error("RESET_ADDRESS must be word aligned");
    end
  end

  abe_apb_state_type state;
  logic [31:0] gpr [0:31];
  logic [31:0] current_instr_address;
  logic [31:0] count_register;
  logic [31:0] link_register;
  logic [31:0] condReg;
  logic [31:0] fixed_exception_register;
  logic [31:0] statusReg;
  logic [31:0] instrWord;
  logic [31:0] next_prdata;
  logic next_pslverr;
  logic apbDone;
  logic apbWr;
  logic execFire;
  logic gprHit;

  abe_decode_if dec();

  abe_decoder u_decoder (
    .instr(pwdata),
    .dec(dec)
  );

  // Bus access
  assign apbDone = psel && penable && pready;
  assign apbWr = apbDone && pwrite && !pslverr;
  assign execFire = apbWr && (paddr == ABE_OFF_INSTR);
  assign gprHit = (paddr[11:7] == ABE_OFF_GPR[11:7]) && (paddr[1:0] == 2'b00);
  assign instrWord = pwdata;

  // Read mux and error decode, sampled in the setup cycle
  always_comb begin
    next_prdata = ABE_RST_WORD;
    next_pslverr = 1'b0;
    if (gprHit) begin
      next_prdata = gpr[paddr[6:2]];
    end else begin
      case (paddr)
        ABE_OFF_INSTR: next_prdata = ABE_RST_WORD;
        ABE_OFF_ADDR: next_prdata = current_instr_address;
        ABE_OFF_COUNT: next_prdata = count_register;
        ABE_OFF_LINK: next_prdata = link_register;
        ABE_OFF_COND: next_prdata = condReg;
        ABE_OFF_EXCEPT: next_prdata = fixed_exception_register;
        ABE_OFF_STATUS: begin
          next_prdata = statusReg;
          next_pslverr = pwrite;
        end
        default: next_pslverr = 1'b1;
      endcase
    end
  end

  // One wait-free access cycle; pready and data come from flops
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state <= ABE_IDLE;
      pready <= 1'b0;
      prdata <= ABE_RST_WORD;
      pslverr <= 1'b0;
    end else begin
      case (state)
        ABE_IDLE: begin
          if (psel && !penable) begin
            state <= ABE_ANSWER;
            pready <= 1'b1;
            pslverr <= next_pslverr;
            prdata <= pwrite ? ABE_RST_WORD : next_prdata;
          end
        end
        ABE_ANSWER: begin
          state <= ABE_IDLE;
          pready <= 1'b0;
          pslverr <= 1'b0;
        end
        default: begin
          state <= ABE_IDLE;
          pready <= 1'b0;
          pslverr <= 1'b0;
        end
      endcase
    end
  end

  // Operands
  logic [31:0] srcFirst;
  logic [31:0] srcSecond;
  logic [31:0] srcLogic;
  logic [31:0] shiftedImm;
  logic [31:0] addA;
  logic [31:0] addB;
  logic addCin;
  logic [31:0] addSum;
  logic addCarry;
  logic addOverflow;
  logic isExtAdd;

  assign srcFirst = gpr[dec.first_source_field];
  assign srcSecond = gpr[dec.second_source_field];
  assign srcLogic = gpr[dec.target_reg_field];
  assign shiftedImm = {dec.immediate_halfword, 16'h0000};
  assign isExtAdd = dec.isAddme || dec.isAddze;

  always_comb begin
    addA = srcFirst;
    addB = ABE_RST_WORD;
    addCin = 1'b0;
    if (dec.isAddis) begin
      // A zero field means the constant zero, not register zero
      addA = (dec.first_source_field == 5'd0) ? ABE_RST_WORD : srcFirst;
      addB = shiftedImm;
    end else if (dec.isAddme) begin
      addB = 32'hFFFF_FFFF;
      addCin = fixed_exception_register[ABE_EXC_CA];
    end else if (dec.isAddze) begin
      addCin = fixed_exception_register[ABE_EXC_CA];
    end
  end

  abe_adder u_adder (
    .a(addA),
    .b(addB),
    .cin(addCin),
    .sum(addSum),
    .carry(addCarry),
    .overflow(addOverflow)
  );

  // Result selection
  logic [31:0] result;
  logic [4:0] destField;
  logic writesGpr;
  logic crUpdate;
  logic ovUpdate;
  logic nextSummary;

  always_comb begin
    result = addSum;
    destField = dec.target_reg_field;
    writesGpr = dec.isAddis || isExtAdd;
    if (dec.isAnd) begin
      result = srcLogic & srcSecond;
    end else if (dec.isAndc) begin
      result = srcLogic & ~srcSecond;
    end else if (dec.isAndi) begin
      result = srcLogic & {16'h0000, dec.immediate_halfword};
    end else if (dec.isAndis) begin
      result = srcLogic & shiftedImm;
    end
    if (dec.isAnd || dec.isAndc || dec.isAndi || dec.isAndis) begin
      destField = dec.first_source_field;
      writesGpr = 1'b1;
    end
  end

  assign ovUpdate = isExtAdd && dec.overflowEnable;
  assign nextSummary = fixed_exception_register[ABE_EXC_SO] || (ovUpdate && addOverflow);
  // Immediate AND forms update the field with no record bit
  assign crUpdate = dec.isAndi || dec.isAndis
    || (dec.record_bit && (isExtAdd || dec.isAnd || dec.isAndc));

  // Branch evaluation
  logic [31:0] ctrAfter;
  logic condBit;
  logic ctrTestOk;
  logic condTestOk;
  logic taken;
  logic [31:0] branchBase;
  logic [31:0] seqAddress;
  logic [31:0] nextInstrAddress;

  // Decrement happens first, so the zero test sees the new count
  assign ctrAfter = dec.branch_options[2] ? count_register
    : count_register - 32'h0000_0001;
  assign condBit = condReg[5'd31 - dec.condition_bit_select];
  assign ctrTestOk = dec.branch_options[2]
    || ((ctrAfter == ABE_RST_WORD) == dec.branch_options[1]);
  assign condTestOk = dec.branch_options[4]
    || (condBit == dec.branch_options[3]);
  assign taken = dec.isBranch || (dec.isCondBranch && ctrTestOk && condTestOk);
  assign branchBase = dec.absolute_address_bit ? ABE_RST_WORD
    : current_instr_address;
  assign seqAddress = current_instr_address + ABE_STEP;
  assign nextInstrAddress = taken ? branchBase + dec.displacement : seqAddress;

  // General registers: bus writes and instruction results
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      for (int i = 0; i < 32; i++) begin
        gpr[i] <= ABE_RST_WORD;
      end
    end else if (execFire && writesGpr) begin
      gpr[destField] <= result;
    end else if (apbWr && gprHit) begin
      gpr[paddr[6:2]] <= pwdata;
    end
  end

  // Instruction address advances after every legal instruction written
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      current_instr_address <= RESET_ADDRESS;
    end else if (execFire && !dec.illegal) begin
      current_instr_address <= nextInstrAddress;
    end else if (apbWr && paddr == ABE_OFF_ADDR) begin
      current_instr_address <= pwdata;
    end
  end

  // Count register
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      count_register <= ABE_RST_WORD;
    end else if (execFire && dec.isCondBranch) begin
      count_register <= ctrAfter;
    end else if (apbWr && paddr == ABE_OFF_COUNT) begin
      count_register <= pwdata;
    end
  end

  // Link register is written even when the branch falls through
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      link_register <= ABE_RST_WORD;
    end else if (execFire && (dec.isBranch || dec.isCondBranch) && dec.link_bit) begin
      link_register <= seqAddress;
    end else if (apbWr && paddr == ABE_OFF_LINK) begin
      link_register <= pwdata;
    end
  end

  // Condition register, field zero in the top nibble
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      condReg <= ABE_RST_WORD;
    end else if (execFire && crUpdate) begin
      condReg[31:28] <= abe_cr0(result, nextSummary);
    end else if (apbWr && paddr == ABE_OFF_COND) begin
      condReg <= pwdata;
    end
  end

  // Exception register: carry, overflow, sticky summary
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      fixed_exception_register <= ABE_RST_WORD;
    end else if (execFire && isExtAdd) begin
      fixed_exception_register[ABE_EXC_CA] <= addCarry;
      if (ovUpdate) begin
        fixed_exception_register[ABE_EXC_OV] <= addOverflow;
        fixed_exception_register[ABE_EXC_SO] <= nextSummary;
      end
    end else if (apbWr && paddr == ABE_OFF_EXCEPT) begin
      fixed_exception_register <= pwdata;
    end
  end

  // Status of the last instruction word written
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      statusReg <= ABE_RST_WORD;
    end else if (execFire) begin
      statusReg <= ABE_RST_WORD;
      statusReg[ABE_STAT_ILLEGAL] <= dec.illegal;
      statusReg[ABE_STAT_TAKEN] <= taken && !dec.illegal;
    end
  end

endmodule : add_logic_branch_exec

//--- common/abe_pkg.sv
package abe_pkg;

  // Register byte offsets on the APB side
  localparam logic [11:0] ABE_OFF_INSTR = 12'h000;
  localparam logic [11:0] ABE_OFF_ADDR = 12'h004;
  localparam logic [11:0] ABE_OFF_COUNT = 12'h008;
  localparam logic [11:0] ABE_OFF_LINK = 12'h00C;
  localparam logic [11:0] ABE_OFF_COND = 12'h010;
  localparam logic [11:0] ABE_OFF_EXCEPT = 12'h014;
  localparam logic [11:0] ABE_OFF_STATUS = 12'h018;
  localparam logic [11:0] ABE_OFF_GPR = 12'h080;

  // Field positions in the exception, status and condition words
  localparam int ABE_EXC_SO = 31;
  localparam int ABE_EXC_OV = 30;
  localparam int ABE_EXC_CA = 29;
  localparam int ABE_STAT_ILLEGAL = 0;
  localparam int ABE_STAT_TAKEN = 1;
  localparam int ABE_CR_EQ_OFFSET = 2;

  // Reset value and address step
  localparam logic [31:0] ABE_RST_WORD = 32'h0000_0000;
  localparam logic [31:0] ABE_STEP = 32'h0000_0004;

  // Opcodes
  localparam logic [5:0] ABE_OP_ADDIS = 6'h0F;
  localparam logic [5:0] ABE_OP_EXT = 6'h1F;
  localparam logic [5:0] ABE_OP_ANDI = 6'h1C;
  localparam logic [5:0] ABE_OP_ANDIS = 6'h1D;
  localparam logic [5:0] ABE_OP_BRANCH = 6'h12;
  localparam logic [5:0] ABE_OP_CBRANCH = 6'h10;
  localparam logic [8:0] ABE_XO_ADDME = 9'h0EA;
  localparam logic [8:0] ABE_XO_ADDZE = 9'h0CA;
  localparam logic [9:0] ABE_XO_AND = 10'h01C;
  localparam logic [9:0] ABE_XO_ANDC = 10'h03C;

  typedef enum logic [1:0] {
    ABE_IDLE = 2'b01,
    ABE_ANSWER = 2'b10
  } abe_apb_state_type;

  // Less-than, greater-than, equal, summary copy; equal at offset 2 of the field
  function automatic logic [3:0] abe_cr0(input logic [31:0] res, input logic so);
    logic [3:0] f;
    f = 4'h0;
    f[3] = res[31];
    f[2] = !res[31] && (res != ABE_RST_WORD);
    f[3 - ABE_CR_EQ_OFFSET] = (res == ABE_RST_WORD);
    f[0] = so;
    return f;
  endfunction : abe_cr0

endpackage : abe_pkg

//--- common/abe_decode_if.sv
`timescale 1ns/1ps
interface abe_decode_if;
  logic isAddis, isAddme, isAddze, isAnd, isAndc, isAndi, isAndis;
  logic isBranch, isCondBranch, illegal;
  logic [4:0] target_reg_field, first_source_field, second_source_field;
  logic [15:0] immediate_halfword;
  logic record_bit, overflowEnable, absolute_address_bit, link_bit;
  logic [4:0] branch_options, condition_bit_select;
  logic [31:0] displacement;
  modport producer(output isAddis, isAddme, isAddze, isAnd, isAndc, isAndi, isAndis,
    isBranch, isCondBranch, illegal, target_reg_field, first_source_field,
    second_source_field, immediate_halfword, record_bit, overflowEnable,
    absolute_address_bit, link_bit, branch_options, condition_bit_select, displacement);
  modport consumer(input isAddis, isAddme, isAddze, isAnd, isAndc, isAndi, isAndis,
    isBranch, isCondBranch, illegal, target_reg_field, first_source_field,
    second_source_field, immediate_halfword, record_bit, overflowEnable,
    absolute_address_bit, link_bit, branch_options, condition_bit_select, displacement);
endinterface : abe_decode_if

//--- src/abe_decoder.sv
`timescale 1ns/1ps
module abe_decoder
  import abe_pkg::*;
(
  // Instruction in
  input wire logic [31:0] instr,
  // Decoded fields out
  abe_decode_if.producer dec
);
  logic [5:0] op;
  assign op = instr[31:26];
  assign dec.isAddis = (op == ABE_OP_ADDIS);
  assign dec.isAddme = (op == ABE_OP_EXT) && (instr[9:1] == ABE_XO_ADDME);
  assign dec.isAddze = (op == ABE_OP_EXT) && (instr[9:1] == ABE_XO_ADDZE);
  assign dec.isAnd = (op == ABE_OP_EXT) && (instr[10:1] == ABE_XO_AND);
  assign dec.isAndc = (op == ABE_OP_EXT) && (instr[10:1] == ABE_XO_ANDC);
  assign dec.isAndi = (op == ABE_OP_ANDI);
  assign dec.isAndis = (op == ABE_OP_ANDIS);
  assign dec.isBranch = (op == ABE_OP_BRANCH);
  assign dec.isCondBranch = (op == ABE_OP_CBRANCH);
  assign dec.illegal = !(dec.isAddis || dec.isAddme || dec.isAddze || dec.isAnd || dec.isAndc
    || dec.isAndi || dec.isAndis || dec.isBranch || dec.isCondBranch);
  assign dec.target_reg_field = instr[25:21];
  assign dec.first_source_field = instr[20:16];
  assign dec.second_source_field = instr[15:11];
  assign dec.immediate_halfword = instr[15:0];
  assign dec.record_bit = instr[0];
  assign dec.overflowEnable = instr[10];
  assign dec.absolute_address_bit = instr[1];
  assign dec.link_bit = instr[0];
  assign dec.branch_options = instr[25:21];
  assign dec.condition_bit_select = instr[20:16];
  // Two zero bits appended, then sign extended to a full word
  assign dec.displacement = dec.isBranch
    ? {{6{instr[25]}}, instr[25:2], 2'b00}
    : {{16{instr[15]}}, instr[15:2], 2'b00};
endmodule : abe_decoder

//--- src/abe_adder.sv
`timescale 1ns/1ps
module abe_adder (
  // Operands
  input wire logic [31:0] a,
  input wire logic [31:0] b,
  input wire logic cin,
  // Results
  output logic [31:0] sum,
  output logic carry,
  output logic overflow
);
  logic [32:0] wide;
  assign wide = {1'b0, a} + {1'b0, b} + {32'h0000_0000, cin};
  assign sum = wide[31:0];
  assign carry = wide[32];
  assign overflow = (a[31] == b[31]) && (sum[31] != a[31]);
endmodule : abe_adder

//--- tb/abe_apb_checker.sv
`timescale 1ns/1ps
module abe_apb_checker
  import abe_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  logic setup;
  assign setup = psel && !penable;
  chk_ready_after_setup: assert property (setup && !pready |=> pready)
    else $error("pready missing after setup");
  chk_ready_one_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  chk_ready_needs_setup: assert property ($rose(pready) |-> $past(setup))
    else $error("pready without setup");
  chk_err_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  chk_write_reads_zero: assert property (pready && pwrite |-> prdata == 32'h0000_0000)
    else $error("prdata nonzero on write");
  chk_status_write_refused: assert property (setup && pwrite && paddr == ABE_OFF_STATUS
      |=> pslverr) else $error("status write accepted");
  chk_unaligned_refused: assert property (setup && paddr[1:0] != 2'b00 |=> pslverr)
    else $error("unaligned access accepted");
  chk_instr_write_taken: assert property (setup && pwrite && paddr == ABE_OFF_INSTR
      |=> pready && !pslverr) else $error("instruction write refused");
  chk_gap_refused: assert property (setup && paddr > 12'h018 && paddr < ABE_OFF_GPR
      |=> pslverr) else $error("unmapped access accepted");
endmodule : abe_apb_checker

bind add_logic_branch_exec abe_apb_checker checker_inst (.ref_clk(ref_clk), .reset(reset),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr));

//--- tb/testbench.sv
`timescale 1ns/1ps
module testbench;
  import abe_pkg::*;
  typedef struct {string name; logic [32:0] exp; logic [32:0] mask;} abe_note_type;
  logic ref_clk, reset, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  abe_note_type notes[$];
  int fail_count, checks, seed;

  add_logic_branch_exec DUT (.ref_clk(ref_clk), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr));

  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  task automatic results();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : results

  // Monitor: each completed transfer consumes the oldest note
  always @(posedge ref_clk) begin
    abe_note_type n;
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1) begin
      n = notes.pop_front();
      checks++;
      if ((({pslverr, prdata}) & n.mask) !== n.exp) begin
        fail_count++;
        $display("unexpected %s exp %h seen %h", n.name, n.exp, {pslverr, prdata});
      end
    end
  end

  // Bus master; an idle cycle between transfers keeps the driver race free
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
      input logic [32:0] e, input logic [32:0] m, input string n);
    int k;
    notes.push_back('{n, e & m, m});
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge ref_clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1) fail_count++;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, 33'h0_0000_0000, 33'h1_FFFF_FFFF, "write");
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] e, input string n);
    xfer(1'b0, a, 32'h0000_0000, {1'b0, e}, 33'h1_FFFF_FFFF, n);
  endtask : rd

  task automatic bad(input logic w, input logic [11:0] a);
    xfer(w, a, 32'h0000_0000, 33'h1_0000_0000, 33'h1_0000_0000, "pslverr");
  endtask : bad

  function automatic logic [11:0] gpr(input int n);
    return ABE_OFF_GPR + 12'(4 * n);
  endfunction : gpr

  function automatic logic [3:0] cr(input logic [31:0] r, input logic s);
    return {r[31], !r[31] && r != 32'h0000_0000, r == 32'h0000_0000, s};
  endfunction : cr

  initial begin
    repeat (20000) @(posedge ref_clk);
    fail_count++;
    results();
  end

  initial begin
    logic [31:0] a, b, r, c, cnd, base, disp;
    logic [15:0] im;
    logic [4:0] bo, bi;
    logic [13:0] bd;
    logic [23:0] li;
    logic aa, tk;
    logic [4:0] bos[8];
    bos = '{5'd16, 5'd18, 5'd0, 5'd8, 5'd2, 5'd10, 5'd12, 5'd4};
    seed = 32'hd440;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    reset = 1'b1;
    repeat (3) @(posedge ref_clk);
    reset <= 1'b0;
    rd(ABE_OFF_ADDR, ABE_RST_WORD, "reset addr");
    rd(ABE_OFF_STATUS, ABE_RST_WORD, "reset status");
    im = 16'($random(seed));
    wr(ABE_OFF_INSTR, {ABE_OP_ADDIS, 5'd3, 5'd0, im});
    rd(gpr(3), {im, 16'h0000}, "addis zero");
    a = $random(seed);
    wr(gpr(1), a);
    wr(ABE_OFF_INSTR, {ABE_OP_ADDIS, 5'd4, 5'd1, im});
    rd(gpr(4), a + {im, 16'h0000}, "addis sum");
    wr(ABE_OFF_EXCEPT, 32'h2000_0000);
    wr(gpr(5), 32'hFFFF_FFFF);
    wr(ABE_OFF_INSTR, {ABE_OP_EXT, 5'd6, 5'd5, 5'd0, 1'b1, ABE_XO_ADDZE, 1'b1});
    rd(gpr(6), 32'h0000_0000, "addze sum");
    rd(ABE_OFF_EXCEPT, 32'h2000_0000, "addze flags");
    rd(ABE_OFF_COND, 32'h2000_0000, "addze cond");
    wr(ABE_OFF_EXCEPT, 32'h0000_0000);
    wr(gpr(7), 32'h8000_0000);
    wr(ABE_OFF_INSTR, {ABE_OP_EXT, 5'd8, 5'd7, 5'd0, 1'b1, ABE_XO_ADDME, 1'b1});
    rd(gpr(8), 32'h7FFF_FFFF, "addme sum");
    rd(ABE_OFF_EXCEPT, 32'hE000_0000, "addme flags");
    rd(ABE_OFF_COND, 32'h5000_0000, "addme cond");
    // Overflow recording on but no overflow: overflow clears, summary stays set
    wr(ABE_OFF_INSTR, {ABE_OP_EXT, 5'd9, 5'd9, 5'd0, 1'b1, ABE_XO_ADDZE, 1'b0});
    rd(gpr(9), 32'h0000_0001, "addze carry in");
    rd(ABE_OFF_EXCEPT, 32'h8000_0000, "sticky summary");
    for (int i = 0; i < 4; i++) begin
      a = $random(seed);
      b = $random(seed);
      wr(gpr(10), a);
      wr(gpr(11), b);
      case (i)
        0: begin
          wr(ABE_OFF_INSTR, {ABE_OP_EXT, 5'd10, 5'd12, 5'd11, ABE_XO_AND, 1'b1});
          r = a & b;
        end
        1: begin
          wr(ABE_OFF_INSTR, {ABE_OP_EXT, 5'd10, 5'd12, 5'd11, ABE_XO_ANDC, 1'b1});
          r = a & ~b;
        end
        2: begin
          wr(ABE_OFF_INSTR, {ABE_OP_ANDI, 5'd10, 5'd12, b[15:0]});
          r = a & {16'h0000, b[15:0]};
        end
        default: begin
          wr(ABE_OFF_INSTR, {ABE_OP_ANDIS, 5'd10, 5'd12, b[15:0]});
          r = a & {b[15:0], 16'h0000};
        end
      endcase
      rd(gpr(12), r, "logic result");
      rd(ABE_OFF_COND, {cr(r, 1'b1), 28'h000_0000}, "logic cond");
    end
    rd(ABE_OFF_ADDR, 32'h0000_0024, "sequential addr");
    li = 24'($random(seed));
    disp = {{6{li[23]}}, li, 2'b00};
    wr(ABE_OFF_ADDR, 32'h0000_1000);
    wr(ABE_OFF_INSTR, {ABE_OP_BRANCH, li, 1'b0, 1'b1});
    rd(ABE_OFF_ADDR, 32'h0000_1000 + disp, "branch rel");
    rd(ABE_OFF_LINK, 32'h0000_1004, "branch link");
    wr(ABE_OFF_INSTR, {ABE_OP_BRANCH, li, 1'b1, 1'b0});
    rd(ABE_OFF_ADDR, disp, "branch abs");
    for (int i = 0; i < 16; i++) begin
      bo = bos[i % 8];
      bi = 5'($random(seed));
      cnd = $random(seed);
      bd = 14'($random(seed));
      aa = (i % 3 == 0);
      c = (i < 8) ? 32'h0000_0001 : 32'h0000_0002;
      wr(ABE_OFF_COND, cnd);
      wr(ABE_OFF_COUNT, c);
      wr(ABE_OFF_ADDR, 32'h0000_4000);
      wr(ABE_OFF_INSTR, {ABE_OP_CBRANCH, bo, bi, bd, aa, 1'b1});
      if (!bo[2]) c = c - 32'h0000_0001;
      tk = (bo[2] || ((c == 32'h0) == bo[1])) && (bo[4] || (cnd[31 - int'(bi)] == bo[3]));
      base = aa ? 32'h0000_0000 : 32'h0000_4000;
      disp = {{16{bd[13]}}, bd, 2'b00};
      rd(ABE_OFF_ADDR, tk ? base + disp : 32'h0000_4004, "cond target");
      rd(ABE_OFF_COUNT, c, "count");
      rd(ABE_OFF_LINK, 32'h0000_4004, "cond link");
      rd(ABE_OFF_STATUS, {30'h0, tk, 1'b0}, "taken");
    end
    bad(1'b0, 12'h01C);
    bad(1'b1, ABE_OFF_STATUS);
    bad(1'b0, 12'h082);
    wr(ABE_OFF_ADDR, 32'h0000_0100);
    wr(ABE_OFF_INSTR, 32'h0000_0000);
    rd(ABE_OFF_ADDR, 32'h0000_0100, "illegal addr");
    rd(ABE_OFF_STATUS, 32'h0000_0001, "illegal status");
    results();
  end
endmodule : testbench
